//--- rtl/rofs_map.svh
// address map, reset values, function codes and widths of the relay selector
`ifndef ROFS_MAP_SVH
`define ROFS_MAP_SVH

// ****************************************************************
// bus geometry
// ****************************************************************
`define ROFS_ADDR_W 4
`define ROFS_DATA_W 8
`define ROFS_CODE_W 4
`define ROFS_AUX_W 13
`define ROFS_NUM_RELAYS 3

// ****************************************************************
// register offsets
// ****************************************************************
`define ROFS_OFS_RELAY_ONE 4'h0
`define ROFS_OFS_RELAY_TWO 4'h1
`define ROFS_OFS_RELAY_THREE 4'h2
`define ROFS_OFS_READBACK 4'h3
`define ROFS_OFS_STARTER 4'h4
`define ROFS_OFS_REJECT 4'h5

// ****************************************************************
// reset values
// ****************************************************************
`define ROFS_RST_RELAY_ONE 4'h1
`define ROFS_RST_RELAY_TWO 4'h2
`define ROFS_RST_RELAY_THREE 4'h6

// ****************************************************************
// function codes
// ****************************************************************
`define ROFS_CODE_NOT_USED 4'h0
`define ROFS_CODE_RUNNING 4'h1
`define ROFS_CODE_FULL_VOLTAGE 4'h2
`define ROFS_CODE_EXT_BYPASS 4'h3
`define ROFS_CODE_REV_ONE 4'h4
`define ROFS_CODE_NO_FAULT 4'h6
`define ROFS_CODE_MAX 4'hC

`endif

//--- rtl/rofs_pkg.sv
// types shared by the relay output function selector
package rofs_pkg;

`include "rofs_map.svh"

  typedef logic [`ROFS_CODE_W-1:0] rofs_code_t;

  typedef enum logic [1:0] {
    ST_STOP,
    ST_RAMP,
    ST_FULL,
    ST_DECEL
  } rofs_state_t;

  typedef struct packed {
    logic enable_cmd;
    logic disable_cmd;
    logic decel_done;
    logic decel_prog;
    logic at_nominal;
    logic fault;
    logic valid;
    logic [`ROFS_AUX_W-1:0] aux;
  } rofs_starter_t;

  typedef struct packed {
    logic [`ROFS_ADDR_W-1:0] addr;
    logic [`ROFS_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } rofs_bus_req_t;

endpackage : rofs_pkg

//--- rtl/rofs_relay_select.sv
// relay output function selector: three selectors, starter tracking, relays
//
// Functional notes
// (R1) three selectors take codes 0 to 12; reset to 1, 2 and 6
// (R2) present relay states are readable in the output readback register
// (R3) each relay follows the condition its selector picks
// (R4) code not used keeps the relay off whatever the starter does
// (R5) running: on with enable edge, off on disable or ramp end
// (R6) full voltage: on at nominal voltage, off on disable command
// (R7) external bypass behaves exactly like full voltage
// (R8) first reversing contactor behaves like running
// (R9) relays stay off after reset until starter state is valid
`timescale 1ns/1ns
`include "rofs_map.svh"


module rofs_relay_select
  import rofs_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,

  // register port
  input wire rofs_bus_req_t bus_req,
  output logic [`ROFS_DATA_W-1:0] bus_rdata,

  // starter conditions
  input wire rofs_starter_t starter,

  // relay coils
  output logic [`ROFS_NUM_RELAYS-1:0] relay_out
);

  // ****************************************************************
  // functions
  // ****************************************************************

  // condition that one function code selects
  function automatic logic cond_of(
    input rofs_code_t code,
    input rofs_state_t st,
    input logic fault,
    input logic [`ROFS_AUX_W-1:0] aux
  );
    logic run;
    logic full;
    run = (st != ST_STOP);
    full = (st == ST_FULL);
    unique case (code)
      `ROFS_CODE_NOT_USED: begin
        cond_of = 1'b0; // R4
      end
      `ROFS_CODE_RUNNING: begin
        cond_of = run; // R5
      end
      `ROFS_CODE_FULL_VOLTAGE: begin
        cond_of = full; // R6
      end
      `ROFS_CODE_EXT_BYPASS: begin
        cond_of = full; // R7
      end
      `ROFS_CODE_REV_ONE: begin
        cond_of = run; // R8
      end
      `ROFS_CODE_NO_FAULT: begin
        cond_of = ~fault;
      end
      default: begin
        if (code <= `ROFS_CODE_MAX) begin
          cond_of = aux[code];
        end else begin
          cond_of = 1'b0;
        end
      end
    endcase
  endfunction : cond_of

  // a code can be stored only when it is in range
  function automatic logic code_ok(input logic [`ROFS_DATA_W-1:0] d);
    code_ok = (d <= {4'h0, `ROFS_CODE_MAX});
  endfunction : code_ok

  // true for the three selector indices
  function automatic logic is_sel_addr(input logic [`ROFS_ADDR_W-1:0] a);
    is_sel_addr = (a == `ROFS_OFS_RELAY_ONE) ||
                  (a == `ROFS_OFS_RELAY_TWO) ||
                  (a == `ROFS_OFS_RELAY_THREE);
  endfunction : is_sel_addr

  // ****************************************************************
  // selector registers
  // ****************************************************************

  rofs_code_t sel_one_ff;
  rofs_code_t sel_two_ff;
  rofs_code_t sel_three_ff;
  rofs_code_t nxt_sel_one;
  rofs_code_t nxt_sel_two;
  rofs_code_t nxt_sel_three;
  logic reject_ff;
  logic nxt_reject;
  logic wr_sel;
  logic wr_ok;

  always_comb begin
    nxt_sel_one = sel_one_ff;
    nxt_sel_two = sel_two_ff;
    nxt_sel_three = sel_three_ff;
    wr_sel = bus_req.wr && is_sel_addr(bus_req.addr);
    wr_ok = code_ok(bus_req.wdata); // R1
    if (wr_sel && wr_ok) begin
      unique case (bus_req.addr)
        `ROFS_OFS_RELAY_ONE: begin
          nxt_sel_one = bus_req.wdata[`ROFS_CODE_W-1:0]; // R1
        end
        `ROFS_OFS_RELAY_TWO: begin
          nxt_sel_two = bus_req.wdata[`ROFS_CODE_W-1:0]; // R1
        end
        `ROFS_OFS_RELAY_THREE: begin
          nxt_sel_three = bus_req.wdata[`ROFS_CODE_W-1:0]; // R1
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sel_one_ff <= `ROFS_RST_RELAY_ONE; // R1
      sel_two_ff <= `ROFS_RST_RELAY_TWO; // R1
      sel_three_ff <= `ROFS_RST_RELAY_THREE; // R1
    end else begin
      sel_one_ff <= nxt_sel_one;
      sel_two_ff <= nxt_sel_two;
      sel_three_ff <= nxt_sel_three;
    end
  end

  // ****************************************************************
  // reject flag
  // ****************************************************************

  // an out-of-range code is dropped and flagged; set wins over clear
  always_comb begin
    nxt_reject = reject_ff;
    if (bus_req.rd && bus_req.addr == `ROFS_OFS_REJECT) begin
      nxt_reject = 1'b0;
    end
    if (wr_sel && !wr_ok) begin
      nxt_reject = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reject_ff <= 1'b0;
    end else begin
      reject_ff <= nxt_reject;
    end
  end

  // ****************************************************************
  // starter tracking
  // ****************************************************************

  rofs_state_t state_ff;
  rofs_state_t nxt_state;
  logic start_req;
  logic stop_req;
  rofs_state_t stop_target;

  // disable outranks a simultaneous enable so the motor is never restarted
  always_comb begin
    start_req = starter.enable_cmd && !starter.disable_cmd;
    stop_req = starter.disable_cmd;
    stop_target = starter.decel_prog ? ST_DECEL : ST_STOP;
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_STOP: begin
        if (start_req) begin
          nxt_state = ST_RAMP; // R5
        end
      end
      ST_RAMP: begin
        if (stop_req) begin
          nxt_state = stop_target; // R5
        end else if (starter.at_nominal) begin
          nxt_state = ST_FULL; // R6
        end
      end
      ST_FULL: begin
        if (stop_req) begin
          nxt_state = stop_target; // R6
        end
      end
      ST_DECEL: begin
        if (start_req) begin
          nxt_state = ST_RAMP;
        end else if (starter.decel_done) begin
          nxt_state = ST_STOP; // R5
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_STOP;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************************************
  // relay conditions
  // ****************************************************************

  rofs_code_t sel_vec [`ROFS_NUM_RELAYS];
  logic [`ROFS_NUM_RELAYS-1:0] cond_now;

  // the next state is used so the relay closes on the enable edge itself
  always_comb begin
    sel_vec[0] = sel_one_ff;
    sel_vec[1] = sel_two_ff;
    sel_vec[2] = sel_three_ff;
    for (int i = 0; i < `ROFS_NUM_RELAYS; i++) begin
      cond_now[i] = cond_of(sel_vec[i], nxt_state, starter.fault,
                            starter.aux); // R3
    end
  end

  // ****************************************************************
  // relay drive
  // ****************************************************************

  logic [`ROFS_NUM_RELAYS-1:0] relay_ff;
  logic [`ROFS_NUM_RELAYS-1:0] nxt_relay;

  // no relay may close before the starter reports a valid state
  always_comb begin
    if (starter.valid) begin
      nxt_relay = cond_now; // R3
    end else begin
      nxt_relay = '0; // R9
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      relay_ff <= '0; // R9
    end else begin
      relay_ff <= nxt_relay;
    end
  end

  assign relay_out = relay_ff;

  // ****************************************************************
  // read port
  // ****************************************************************

  logic [`ROFS_DATA_W-1:0] rdata_ff;
  logic [`ROFS_DATA_W-1:0] nxt_rdata;

  // data stand only in the cycle after the read strobe
  always_comb begin
    nxt_rdata = '0;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `ROFS_OFS_RELAY_ONE: begin
          nxt_rdata = {4'h0, sel_one_ff};
        end
        `ROFS_OFS_RELAY_TWO: begin
          nxt_rdata = {4'h0, sel_two_ff};
        end
        `ROFS_OFS_RELAY_THREE: begin
          nxt_rdata = {4'h0, sel_three_ff};
        end
        `ROFS_OFS_READBACK: begin
          nxt_rdata = {5'h00, relay_ff}; // R2
        end
        `ROFS_OFS_STARTER: begin
          nxt_rdata = {6'h00, state_ff};
        end
        `ROFS_OFS_REJECT: begin
          nxt_rdata = {7'h00, reject_ff};
        end
        default: begin
          nxt_rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign bus_rdata = rdata_ff;

endmodule : rofs_relay_select

//--- verif/rofs_coil_model.sv
// relay coil model on the far side of the relay drive
`timescale 1ns/1ns

module rofs_coil_model
  import rofs_pkg::*;
(
  // coil drive
  input wire logic [2:0] relay_out,
  // coil state
  output logic [2:0] coil_on
);
  // coils simply follow their drive, no latching of their own
  assign coil_on = relay_out;
endmodule : rofs_coil_model

//--- verif/rofs_relay_select_monitor.sv
// port checker of the relay output function selector
`timescale 1ns/1ns

module rofs_monitor
  import rofs_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // watched ports
  input wire rofs_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire rofs_starter_t starter,
  input wire logic [2:0] relay_out
);
  // ****
  // shadow of the three selectors
  // ****
  logic [2:0][3:0] sel_ff;
  logic [2:0][3:0] nxt_sel;
  always_comb begin
    nxt_sel = sel_ff;
    if (bus_req.wr && bus_req.addr < 4'h3 && bus_req.wdata < 8'h0D) begin
      nxt_sel[bus_req.addr[1:0]] = bus_req.wdata[3:0];
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sel_ff <= {4'h6, 4'h2, 4'h1};
    end else begin
      sel_ff <= nxt_sel;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_off; !starter.valid |=> relay_out == 3'h0; endproperty
  a_off: assert property (p_off) else $error("relay on when invalid");
  property p_idle; !bus_req.rd |=> bus_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("stray read data");
  property p_sel; bus_req.rd && bus_req.addr < 4'h3 |=>
    bus_rdata == {4'h0, sel_ff[$past(bus_req.addr)]}; endproperty
  a_sel: assert property (p_sel) else $error("selector read");
  property p_back; bus_req.rd && bus_req.addr == 4'h3 |=>
    bus_rdata == {5'h00, $past(relay_out)}; endproperty
  a_back: assert property (p_back) else $error("readback wrong");
  property p_unused; sel_ff[2] == 4'h0 |=> !relay_out[2]; endproperty
  a_unused: assert property (p_unused) else $error("unused on");
  property p_run; sel_ff[0] == 4'h1 && starter.valid && starter.enable_cmd
    && !starter.disable_cmd && !bus_req.wr |=> relay_out[0]; endproperty
  a_run: assert property (p_run) else $error("running not on");
  property p_full_off; sel_ff[1] == 4'h2 && starter.disable_cmd
    && !bus_req.wr |=> !relay_out[1]; endproperty
  a_full_off: assert property (p_full_off) else $error("full not off");
  property p_full_hold; sel_ff[1] == 4'h2 && relay_out[1] && starter.valid
    && !starter.disable_cmd && !bus_req.wr && $stable(sel_ff[1])
    |=> relay_out[1]; endproperty
  a_full_hold: assert property (p_full_hold) else $error("full dropped");
endmodule : rofs_monitor

bind rofs_relay_select rofs_monitor i_rofs_monitor (.clock(clock),
  .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .starter(starter), .relay_out(relay_out));

//--- verif/tb_top.sv
// self-checking bench of the relay output function selector
`timescale 1ns/1ns

module tb_top
  import rofs_pkg::*;
;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  rofs_bus_req_t req = '0;
  rofs_starter_t st = '0;
  logic [7:0] rdata;
  logic [2:0] rly;
  logic [2:0] coil;
  int err_count = 0;
  int compares = 0;
  always #50 clock = ~clock;
  rofs_relay_select i_rofs_relay_select (.clock(clock), .rst_b(rst_b),
    .bus_req(req), .bus_rdata(rdata), .starter(st), .relay_out(rly));
  rofs_coil_model i_rofs_coil_model (.relay_out(rly), .coil_on(coil));
  // ****
  // access and compare tasks
  // ****
  task complete_run;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  task cmp8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp8
  task chk_rly(input logic [2:0] exp);
    #1;
    compares++;
    if (rly !== exp || coil !== exp) begin
      err_count++;
      $display("mismatch t=%0t got %h exp %h", $time, rly, exp);
    end
  endtask : chk_rly
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    req.rd <= 1'b0;
    #1;
    cmp8(rdata, exp);
  endtask : rd
  // enable, disable, ramp end
  task pulse(input logic [2:0] m);
    @(posedge clock);
    {st.enable_cmd, st.disable_cmd, st.decel_done} <= m;
    @(posedge clock);
    {st.enable_cmd, st.disable_cmd, st.decel_done} <= 3'h0;
  endtask : pulse
  // valid, at nominal, decel programmed
  task lv(input logic [2:0] m);
    @(posedge clock);
    {st.valid, st.at_nominal, st.decel_prog} <= m;
    @(posedge clock);
  endtask : lv
  initial begin
    #200000;
    err_count++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    rd(4'h0, 8'h01);
    rd(4'h1, 8'h02);
    rd(4'h2, 8'h06);
    lv(3'b000);
    chk_rly(3'h0);
    lv(3'b100);
    chk_rly(3'h4);
    pulse(3'b100);
    chk_rly(3'h5);
    rd(4'h3, 8'h05);
    lv(3'b110);
    chk_rly(3'h7);
    lv(3'b101);
    chk_rly(3'h7);
    pulse(3'b010);
    chk_rly(3'h5);
    pulse(3'b001);
    chk_rly(3'h4);
    wr(4'h0, 8'h0D);
    rd(4'h0, 8'h01);
    rd(4'h5, 8'h01);
    wr(4'h2, 8'h0C);
    rd(4'h2, 8'h0C);
    wr(4'h0, 8'h04);
    wr(4'h1, 8'h03);
    wr(4'h2, 8'h00);
    chk_rly(3'h0);
    pulse(3'b100);
    chk_rly(3'h1);
    lv(3'b110);
    chk_rly(3'h3);
    lv(3'b000);
    chk_rly(3'h0);
    rd(4'hF, 8'h00);
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    rd(4'h0, 8'h01);
    rd(4'h1, 8'h02);
    rd(4'h2, 8'h06);
    complete_run();
  end
endmodule : tb_top
